// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 0, reset = 1;
    logic cyc = 0, stb = 0, we = 0, ack;
    logic [15:0] adr = 0;
    logic [3:0] sel = 0, pend = 0;
    logic [31:0] wdat = 0, dat_o, rd;
    logic [2:0] prio = 0;
    logic valid = 0, dropped = 0, srp = 0, is_ip = 0, max_x = 0, prob = 0, done = 0;
    logic [1:0] q = 0, col = 0, dscp = 2'b11, eq, ocol, gq, shp;
    logic drop, mark, remap, pbp, gv;
    logic [11:0] vid = 0, port_default_vlan_id = 12'h123, vid_o;
    logic [11:0] pol [9] = '{12'h021, 12'h021, 12'h421, 12'h421, 12'h021, 12'h025, 12'h020, 12'h023, 12'h041};
    logic [4:0] fl [9] = '{5'h0a, 5'h06, 5'h0a, 5'h06, 5'h16, 5'h16, 5'h06, 5'h06, 5'h04};
    logic [2:0] ex [9] = '{3'h3, 3'h7, 3'h7, 3'h3, 3'h3, 3'h7, 3'h3, 3'h5, 3'h6};
    logic [6:0] wt [4] = '{7'h01, 7'h01, 7'h05, 7'h01};
    int fails = 0, samples_checked = 0, cur, rem;

    port_qos_config dut_u (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ingress_prio_i(prio), .pkt_valid_i(valid), .pkt_queue_i(q), .pkt_color_i(col),
        .pkt_dropped_i(dropped), .pkt_srp_i(srp), .pkt_is_ip_i(is_ip), .dscp_color_i(dscp),
        .wred_max_exceeded_i(max_x), .wred_prob_hit_i(prob), .egress_queue_o(eq), .pkt_drop_o(drop),
        .pkt_color_o(ocol), .color_mark_en_o(mark), .color_remap_en_o(remap), .port_based_police_o(pbp),
        .egress_vid_i(vid), .port_default_vlan_id_i(port_default_vlan_id), .egress_vid_o(vid_o), .q_pending_i(pend),
        .tx_done_i(done), .grant_queue_o(gq), .grant_valid_o(gv), .shaper_mode_o(shp));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            wrap_up();
        end
        rd = dat_o;
        cyc <= 0;
        stb <= 0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1, a, d, 4'hf);
    endtask

    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        bus(0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask

    // inputs changed at the last edge: let the next edge capture, look at the falling edge
    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pkt(input logic [1:0] qq, input logic [1:0] c, input logic [4:0] f);
        @(posedge core_clk);
        {srp, max_x, prob, is_ip, dropped} <= f;
        q <= qq;
        col <= c;
        valid <= 1;
        @(posedge core_clk);
        valid <= 0;
        @(negedge core_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 0;
        rc(16'h1808, 32'h33221100);
        rc(16'h180c, 32'h00000020);
        rc(16'h1900, 32'h0);
        rc(16'h1914, 32'h00000180);
        rc(16'h1904, 32'h0);
        wr(16'h1808, 32'hffffffff);
        rc(16'h1808, 32'h33333333);
        wr(16'h1808, 32'h00112233);
        for (int p = 0; p < 8; p++) begin
            @(posedge core_clk);
            prio <= 3'(p);
            settle();
            chk(eq, 32'(3 - p / 2));
        end
        wr(16'h180c, 32'hffffffff);
        rc(16'h180c, 32'h00000fff);
        for (int i = 0; i < 9; i++) begin
            wr(16'h180c, 32'(pol[i]));
            pkt(2'b00, 2'b01, fl[i]);
            chk({drop, ocol}, 32'(ex[i]));
        end
        @(posedge core_clk);
        dscp <= 2'b10;
        wr(16'h180c, 32'h021);
        pkt(2'b00, 2'b01, 5'h02);
        chk({drop, ocol}, 32'h2);
        wr(16'h180c, 32'h099);
        settle();
        chk({mark, remap, pbp}, 32'h7);
        wr(16'h180c, 32'h001);
        settle();
        chk({mark, remap, pbp}, 32'h0);
        bus(1, 16'h1903, 32'h00000002, 4'h1);
        rc(16'h1900, 32'h2);
        wr(16'h1914, 32'h510);
        rc(16'h1914, 32'h510);
        wr(16'h1914, 32'h550);
        rc(16'h1914, 32'h510);
        wr(16'h1914, 32'h530);
        rc(16'h1914, 32'h510);
        wr(16'h1900, 32'hffffffff);
        rc(16'h1900, 32'h3);
        rc(16'h1914, 32'h180);
        wr(16'h1914, 32'h1a0);
        @(posedge core_clk);
        vid <= 12'h005;
        settle();
        chk(vid_o, 32'h005);
        wr(16'h1904, 32'h1);
        settle();
        chk(vid_o, 32'h123);
        @(posedge core_clk);
        vid <= 12'h000;
        settle();
        chk(vid_o, 32'h000);
        wr(16'h1804, 32'hffffffff);
        rc(16'h1804, 32'h00070003);
        wr(16'h1804, 32'h1);
        wr(16'h180c, 32'h001);
        pkt(2'b01, 2'b01, 5'h00);
        pkt(2'b01, 2'b10, 5'h00);
        pkt(2'b01, 2'b11, 5'h00);
        wr(16'h180c, 32'h801);
        pkt(2'b01, 2'b11, 5'h00);
        pkt(2'b01, 2'b11, 5'h01);
        for (int t = 0; t < 4; t++) begin
            wr(16'h180c, 32'h1 | (t << 8));
            rc(16'h1810, (t == 3) ? 32'h2 : 32'h1);
        end
        // weighted round robin with queue 2 at weight 5
        @(posedge core_clk);
        pend <= 4'hf;
        settle();
        settle();
        chk(gv, 32'h1);
        cur = int'(gq);
        rem = int'(wt[cur]);
        for (int k = 0; k < 10; k++) begin
            @(posedge core_clk);
            done <= 1;
            @(posedge core_clk);
            done <= 0;
            rem--;
            if (rem == 0) begin
                cur = (cur + 3) % 4;
                rem = int'(wt[cur]);
            end
            settle();
            chk(gq, 32'(cur));
        end
        wr(16'h1900, 32'h0);
        wr(16'h1914, 32'h100);
        @(posedge core_clk);
        pend <= 4'b1010;
        settle();
        settle();
        chk({gv, gq}, 32'h7);
        chk(shp, 32'h2);
        @(posedge core_clk);
        pend <= 4'b0110;
        settle();
        settle();
        chk(gq, 32'h2);
        chk(shp, 32'h1);
        rc(16'h1a00, 32'h0);
        wrap_up();
    end
endmodule // tb
`default_nettype wire

// >>> rtl/port_qos_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_qos_params.svh"
// Functional notes
// - eight 4-bit fields, low two bits pick queue
// - reset map 0,1->q0 2,3->q1 4,5->q2 6,7->q3
// - bit 11 counts dropped only, else all
// - drop-all while over max, else probability
// - type field picks red/yellow/green/dropped counter
// - bit 7 selects per-port per-queue policing
// - non-IP colour field, reset 01
// - bit 4 enables DSCP colour marking
// - bit 3 remaps DSCP colour when colour aware
// - bit 2 lets WRED drop SRP packets
// - bit 1 colour-blind, clear colour-aware
// - bit 0 enables policing and WRED, reset off
// - queue index selects indexed queue registers
// - queue index low byte at byte 0x1903
// - replace non-zero egress VID with port default
// - scheduler 00 strict, 10 WRR, reset 10
// - strict priority serves queue 3 first
// - WRR sends weight packets then next queue
// - shaper 00 none 01 credit 10 time-aware
// - pointer register picks port and queue
// - weight is packets per turn, zero served as one
module port_qos_config import port_qos_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // ingress classification and policing
    input wire logic [2:0] ingress_prio_i,
    input wire logic pkt_valid_i,
    input wire logic [1:0] pkt_queue_i,
    input wire logic [1:0] pkt_color_i,
    input wire logic pkt_dropped_i,
    input wire logic pkt_srp_i,
    input wire logic pkt_is_ip_i,
    input wire logic [1:0] dscp_color_i,
    input wire logic wred_max_exceeded_i,
    input wire logic wred_prob_hit_i,
    output logic [1:0] egress_queue_o,
    output logic pkt_drop_o,
    output logic [1:0] pkt_color_o,
    output logic color_mark_en_o,
    output logic color_remap_en_o,
    output logic port_based_police_o,
    // egress vlan
    input wire logic [11:0] egress_vid_i,
    input wire logic [11:0] port_default_vlan_id_i,
    output logic [11:0] egress_vid_o,
    // egress scheduler
    input wire logic [3:0] q_pending_i,
    input wire logic tx_done_i,
    output logic [1:0] grant_queue_o,
    output logic grant_valid_o,
    output logic [1:0] shaper_mode_o
);
    state_t s_q, s_d;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i+:8] = d[8*i+:8];
            end
        end
        return r;
    endfunction

    // pack the map with reserved upper field bits as zero
    function automatic logic [31:0] map_word(input logic [7:0][1:0] m);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 8; i++) begin
            r[4*i+:2] = m[i];
        end
        return r;
    endfunction

    function automatic logic [31:0] sched_word(input logic [6:0] w, input logic [1:0] m, input logic [1:0] s);
        return {17'h0, w, m, s, 4'h0};
    endfunction

    function automatic logic [1:0] highest(input logic [3:0] p);
        logic [1:0] r;
        r = 2'd0;
        for (int i = 0; i < 4; i++) begin
            if (p[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // next pending queue below cur, wrapping from 0 to 3
    function automatic logic [1:0] next_q(input logic [1:0] c, input logic [3:0] p);
        logic [1:0] r;
        logic [1:0] k;
        r = c;
        for (int i = 3; i >= 1; i--) begin
            k = c - 2'(i);
            if (p[k]) begin
                r = k;
            end
        end
        return r;
    endfunction

    logic hit, wr, strict;
    logic [15:0] addr;
    logic [31:0] w;
    logic [6:0] wt;
    logic [7:0] sent_n;
    logic [3:0] cidx;
    logic [1:0] lk;
    assign lk = s_q.map[ingress_prio_i];

    always_comb begin
        s_d = s_q;
        w = 32'h0;
        addr = {wb_adr_i[15:2], 2'b00};
        hit = wb_cyc_i & wb_stb_i;
        wr = hit & wb_we_i & s_q.ack;
        // registered answer one cycle after the request, dropped after one cycle
        s_d.ack = hit & ~s_q.ack;
        if (hit && !s_q.ack && !wb_we_i) begin
            unique case (addr)
                `ADDR_PORT_PTR: s_d.rdata = {13'h0, s_q.ptr_port, 14'h0, s_q.ptr_q};
                `ADDR_PRIO_MAP: s_d.rdata = map_word(s_q.map);
                `ADDR_POLICE_CTRL: s_d.rdata = {20'h0, s_q.pol};
                `ADDR_MON_DATA: s_d.rdata = {16'h0, s_q.cnt[{s_q.ptr_q, s_q.pol[`POL_TYPE_LO+:2]}]};
                `ADDR_TXQ_INDEX: s_d.rdata = {30'h0, s_q.qidx};
                `ADDR_VID_REPLACE: s_d.rdata = {31'h0, s_q.vrep};
                `ADDR_TXQ_SCHED: s_d.rdata = sched_word(s_q.wgt[s_q.qidx], s_q.mode[s_q.qidx], s_q.shp[s_q.qidx]);
                default: s_d.rdata = 32'h0;
            endcase
        end
        // writes land at the edge where the master sees ack
        if (wr) begin
            unique case (addr)
                `ADDR_PORT_PTR: begin
                    w = merge({13'h0, s_q.ptr_port, 14'h0, s_q.ptr_q}, wb_dat_i, wb_sel_i);
                    s_d.ptr_port = w[18:16];
                    s_d.ptr_q = w[1:0];
                end
                `ADDR_PRIO_MAP: begin
                    w = merge(map_word(s_q.map), wb_dat_i, wb_sel_i);
                    for (int i = 0; i < 8; i++) begin
                        s_d.map[i] = w[4*i+:2];
                    end
                end
                `ADDR_POLICE_CTRL: begin
                    w = merge({20'h0, s_q.pol}, wb_dat_i, wb_sel_i);
                    s_d.pol = w[11:0];
                end
                `ADDR_TXQ_INDEX: begin
                    // the byte at 0x1903 is lane 0 of this word
                    w = merge({30'h0, s_q.qidx}, wb_dat_i, wb_sel_i);
                    s_d.qidx = w[1:0];
                end
                `ADDR_VID_REPLACE: begin
                    w = merge({31'h0, s_q.vrep}, wb_dat_i, wb_sel_i);
                    s_d.vrep = w[0];
                end
                `ADDR_TXQ_SCHED: begin
                    w = merge(sched_word(s_q.wgt[s_q.qidx], s_q.mode[s_q.qidx], s_q.shp[s_q.qidx]), wb_dat_i, wb_sel_i);
                    s_d.wgt[s_q.qidx] = w[14:8];
                    // reserved codes are refused, the old value stays
                    if (w[7:6] == `SCHED_STRICT || w[7:6] == `SCHED_WRR) begin
                        s_d.mode[s_q.qidx] = w[7:6];
                    end
                    if (w[5:4] != `SHAPER_RSVD) begin
                        s_d.shp[s_q.qidx] = w[5:4];
                    end
                end
                default: begin
                end
            endcase
        end
        // priority regeneration
        s_d.egress_queue = lk;
        // policing and WRED drop decision
        s_d.drop = pkt_valid_i & s_q.pol[`POL_ENABLE]
            & (~pkt_srp_i | s_q.pol[`POL_SRP_DROP])
            & (s_q.pol[`POL_DROP_ALL] ? wred_max_exceeded_i : wred_prob_hit_i);
        // colour given to the frame
        if (s_q.pol[`POL_BLIND]) begin
            s_d.color = 2'b01;
        end else if (!pkt_is_ip_i) begin
            s_d.color = s_q.pol[`POL_NONIP_LO+:2];
        end else begin
            s_d.color = dscp_color_i;
        end
        // monitor counters per queue and colour
        cidx = {pkt_queue_i, pkt_color_i};
        if (pkt_valid_i && s_q.pol[`POL_ENABLE]) begin
            if (pkt_color_i != 2'b00 && (!s_q.pol[`POL_DROPPED_ONLY] || pkt_dropped_i)) begin
                s_d.cnt[cidx] = s_q.cnt[cidx] + 16'h1;
            end
            if (pkt_dropped_i) begin
                s_d.cnt[{pkt_queue_i, 2'b00}] = s_q.cnt[{pkt_queue_i, 2'b00}] + 16'h1;
            end
        end
        // egress vlan id replacement
        s_d.vid = (s_q.vrep && egress_vid_i != 12'h0) ? port_default_vlan_id_i : egress_vid_i;
        // scheduler; the port mode is held in queue 0's entry
        strict = s_q.mode[0] == `SCHED_STRICT;
        wt = (s_q.wgt[s_q.cur] == 7'h0) ? 7'h1 : s_q.wgt[s_q.cur];
        sent_n = {1'b0, s_q.sent} + ((tx_done_i && s_q.grant_vld) ? 8'h1 : 8'h0);
        if (!q_pending_i[s_q.cur] || sent_n >= {1'b0, wt}) begin
            s_d.cur = next_q(s_q.cur, q_pending_i);
            s_d.sent = 7'h0;
        end else begin
            s_d.sent = sent_n[6:0];
        end
        if (strict) begin
            s_d.grant = highest(q_pending_i);
            s_d.grant_vld = |q_pending_i;
        end else begin
            s_d.grant = s_d.cur;
            s_d.grant_vld = q_pending_i[s_d.cur];
        end
        s_d.shaper = s_q.shp[s_d.grant];
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.map <= `MAP_RST;
            s_q.pol <= `POL_RST;
            s_q.mode <= {4{`SCHED_RST}};
            s_q.shp <= {4{`SHAPER_RST}};
            s_q.wgt <= {4{`WEIGHT_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign egress_queue_o = s_q.egress_queue;
    assign pkt_drop_o = s_q.drop;
    assign pkt_color_o = s_q.color;
    assign color_mark_en_o = s_q.pol[`POL_MARK];
    assign color_remap_en_o = s_q.pol[`POL_REMAP];
    assign port_based_police_o = s_q.pol[`POL_PORT_BASED];
    assign egress_vid_o = s_q.vid;
    assign grant_queue_o = s_q.grant;
    assign grant_valid_o = s_q.grant_vld;
    assign shaper_mode_o = s_q.shaper;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // register bus handshake
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");

    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");

    // register contents and read-back
    a_map_reset: assert property ($fell(reset) |-> map_word(s_q.map) == 32'h33221100)
        else $error("map reset wrong");

    a_rsvd_zero: assert property (hit && !wb_ack_o && !wb_we_i && addr == `ADDR_POLICE_CTRL |=> wb_dat_o[31:12] == 20'h0)
        else $error("reserved bits set");

    a_map_rsvd: assert property (hit && !wb_ack_o && !wb_we_i && addr == `ADDR_PRIO_MAP |=> (wb_dat_o & 32'hcccccccc) == 32'h0)
        else $error("map reserved bits set");

    a_qidx_rsvd: assert property (hit && !wb_ack_o && !wb_we_i && addr == `ADDR_TXQ_INDEX |=> wb_dat_o[31:2] == 30'h0)
        else $error("index reserved bits set");

    a_sched_rsvd: assert property (hit && !wb_ack_o && !wb_we_i && addr == `ADDR_TXQ_SCHED |=> wb_dat_o[3:0] == 4'h0)
        else $error("scheduler reserved bits set");

    a_ptr_rsvd: assert property (hit && !wb_ack_o && !wb_we_i && addr == `ADDR_PORT_PTR |=> wb_dat_o[15:2] == 14'h0)
        else $error("pointer reserved bits set");

    a_police_write: assert property (wr && addr == `ADDR_POLICE_CTRL && wb_sel_i[1:0] == 2'b11 |=> s_q.pol == $past(wb_dat_i[11:0]))
        else $error("police write lost");

    a_index_byte: assert property (wr && addr == `ADDR_TXQ_INDEX && wb_sel_i[0] |=> s_q.qidx == $past(wb_dat_i[1:0]))
        else $error("queue index write lost");

    a_pointer_write: assert property (wr && addr == `ADDR_PORT_PTR && wb_sel_i == 4'hf |=> s_q.ptr_q == $past(wb_dat_i[1:0]))
        else $error("pointer write lost");

    a_weight_write: assert property (wr && addr == `ADDR_TXQ_SCHED && wb_sel_i[1] |=> s_q.wgt[$past(s_q.qidx)] == $past(wb_dat_i[14:8]))
        else $error("weight write lost");

    a_mode_legal: assert property (s_q.mode[s_q.qidx] != 2'b01 && s_q.mode[s_q.qidx] != 2'b11)
        else $error("reserved scheduler code held");

    a_shaper_legal: assert property (s_q.shp[s_q.qidx] != `SHAPER_RSVD)
        else $error("reserved shaper code held");

    a_shaper_out: assert property (shaper_mode_o != `SHAPER_RSVD)
        else $error("reserved shaper code driven");

    // priority map
    a_queue_lookup: assert property (1'b1 |=> egress_queue_o == $past(lk))
        else $error("queue map wrong");

    // policing and WRED decisions
    a_police_off: assert property (!s_q.pol[`POL_ENABLE] |=> !pkt_drop_o)
        else $error("drop while off");

    a_drop_all: assert property (pkt_valid_i && s_q.pol[`POL_ENABLE] && s_q.pol[`POL_DROP_ALL] && wred_max_exceeded_i && !pkt_srp_i |=> pkt_drop_o)
        else $error("drop-all missed");

    a_prob_drop: assert property (pkt_valid_i && s_q.pol[`POL_ENABLE] && !s_q.pol[`POL_DROP_ALL] && wred_prob_hit_i && !pkt_srp_i |=> pkt_drop_o)
        else $error("probability drop missed");

    a_prob_keep: assert property (!s_q.pol[`POL_DROP_ALL] && !wred_prob_hit_i |=> !pkt_drop_o)
        else $error("drop without probability hit");

    a_srp_exempt: assert property (pkt_srp_i && !s_q.pol[`POL_SRP_DROP] |=> !pkt_drop_o)
        else $error("srp dropped");

    // colour given to frames
    a_color_blind: assert property (s_q.pol[`POL_BLIND] |=> pkt_color_o == 2'b01)
        else $error("blind colour wrong");

    a_nonip_color: assert property (!s_q.pol[`POL_BLIND] && !pkt_is_ip_i |=> pkt_color_o == $past(s_q.pol[`POL_NONIP_LO+:2]))
        else $error("non-ip colour wrong");

    a_dscp_color: assert property (!s_q.pol[`POL_BLIND] && pkt_is_ip_i |=> pkt_color_o == $past(dscp_color_i))
        else $error("dscp colour wrong");

    // monitor counters move only on counted packets
    a_counter_hold: assert property (!pkt_valid_i |=> $stable(s_q.cnt))
        else $error("counter moved without packet");

    a_counter_off: assert property (!s_q.pol[`POL_ENABLE] |=> $stable(s_q.cnt))
        else $error("counter moved while off");

    // egress vlan id
    a_vid_swap: assert property (s_q.vrep && egress_vid_i != 12'h0 |=> egress_vid_o == $past(port_default_vlan_id_i))
        else $error("vid not replaced");

    a_vid_keep: assert property (!s_q.vrep |=> egress_vid_o == $past(egress_vid_i))
        else $error("vid replaced while off");

    a_vid_zero: assert property (egress_vid_i == 12'h0 |=> egress_vid_o == 12'h0)
        else $error("zero vid replaced");

    // egress scheduler
    a_strict_top: assert property (strict && q_pending_i[3] |=> grant_queue_o == 2'd3 && grant_valid_o)
        else $error("strict order wrong");

    a_strict_next: assert property (strict && q_pending_i[3:2] == 2'b01 |=> grant_queue_o == 2'd2 && grant_valid_o)
        else $error("strict second queue wrong");

    a_strict_empty: assert property (strict && q_pending_i == 4'h0 |=> !grant_valid_o)
        else $error("grant with nothing pending");

    c_wrr_turn: cover property (!strict && tx_done_i && grant_valid_o ##1 grant_queue_o != $past(grant_queue_o));
    c_index_write: cover property (wr && addr == `ADDR_TXQ_INDEX && wb_sel_i == 4'h1);
    c_drop_seen: cover property (pkt_drop_o);
    c_strict_grant: cover property (strict && grant_valid_o);
    c_counter_read: cover property (hit && !wb_we_i && addr == `ADDR_MON_DATA);
endmodule // port_qos_config
`default_nettype wire

// >>> rtl/port_qos_params.svh
`ifndef PORT_QOS_PARAMS_SVH
`define PORT_QOS_PARAMS_SVH
// byte addresses on the register bus (port 1 of the bank)
`define ADDR_PORT_PTR 16'h1804
`define ADDR_PRIO_MAP 16'h1808
`define ADDR_POLICE_CTRL 16'h180c
`define ADDR_MON_DATA 16'h1810
`define ADDR_TXQ_INDEX 16'h1900
`define ADDR_VID_REPLACE 16'h1904
`define ADDR_TXQ_SCHED 16'h1914
// policing control bit positions
`define POL_ENABLE 0
`define POL_BLIND 1
`define POL_SRP_DROP 2
`define POL_REMAP 3
`define POL_MARK 4
`define POL_NONIP_LO 5
`define POL_PORT_BASED 7
`define POL_TYPE_LO 8
`define POL_DROP_ALL 10
`define POL_DROPPED_ONLY 11
// reset values
`define MAP_RST 16'hfa50
`define POL_RST 12'h020
`define SCHED_RST 2'b10
`define SHAPER_RST 2'b00
`define WEIGHT_RST 7'h01
// scheduler and shaper codes
`define SCHED_STRICT 2'b00
`define SCHED_WRR 2'b10
`define SHAPER_RSVD 2'b11
`endif

// >>> rtl/port_qos_pkg.sv
package port_qos_pkg;
`include "port_qos_params.svh"

    typedef struct packed {
        logic [7:0][1:0] map;
        logic [11:0] pol;
        logic [1:0] qidx;
        logic vrep;
        logic [3:0][1:0] mode;
        logic [3:0][1:0] shp;
        logic [3:0][6:0] wgt;
        logic [2:0] ptr_port;
        logic [1:0] ptr_q;
        logic [15:0][15:0] cnt;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] egress_queue;
        logic drop;
        logic [1:0] color;
        logic [11:0] vid;
        logic [1:0] cur;
        logic [6:0] sent;
        logic [1:0] grant;
        logic grant_vld;
        logic [1:0] shaper;
    } state_t;
endpackage
